// ### verilog/simd_fp_exc_pkg.sv
// Shared constants and carriers of the SIMD floating-point
// pre-computation exception unit.
// Assumes a single core clock and a plain register port.
package simd_fp_exc_pkg;

	// ************************************************
	// Register map and field positions
	// ************************************************
	localparam logic [3:0] CSR_ADDR = 4'h0;
	localparam logic [3:0] OS_CTRL_ADDR = 4'h4;
	localparam int INV_FLAG_BIT = 0;
	localparam int DEN_FLAG_BIT = 1;
	localparam int DZ_FLAG_BIT = 2;
	localparam int DAZ_BIT = 6;
	localparam int INV_MASK_BIT = 7;
	localparam int DEN_MASK_BIT = 8;
	localparam int DZ_MASK_BIT = 9;
	localparam int FTZ_BIT = 15;
	localparam int OS_SUPPORT_BIT = 10;
	localparam logic [31:0] CSR_WMASK = 32'h0000_83C7;
	localparam logic [31:0] CSR_RESET = 32'h0000_0380;
	localparam logic OS_SUPPORT_RESET = 1'b0;

	// ************************************************
	// Encodings of special values
	// ************************************************
	localparam logic [31:0] SGL_INDEF = 32'hFFC0_0000;
	localparam logic [63:0] DBL_INDEF = 64'hFFF8_0000_0000_0000;
	localparam logic [31:0] INT_INDEF = 32'h8000_0000;
	localparam logic [31:0] SGL_INF = 32'h7F80_0000;
	localparam logic [63:0] DBL_INF = 64'h7FF0_0000_0000_0000;
	localparam logic [63:0] SGL_QUIET = 64'h0000_0000_0040_0000;
	localparam logic [63:0] DBL_QUIET = 64'h0008_0000_0000_0000;
	localparam logic [10:0] SGL_INT_EXP = 11'h09E;
	localparam logic [10:0] DBL_INT_EXP = 11'h41E;
	localparam logic [2:0] UNORD_FLAGS = 3'h7;

	// ************************************************
	// Types
	// ************************************************
	typedef enum logic [3:0] {OP_ADD, OP_SUB, OP_ADDSUB, OP_MUL, OP_DIV, OP_SQRT, OP_MAX, OP_MIN,
		OP_CMP, OP_COMI, OP_CVT_FP, OP_CVT_INT, OP_CVT_FROM_INT, OP_APPROX} op_t;
	typedef enum logic [2:0] {P_EQ, P_LT, P_LE, P_UNORD, P_NEQ, P_NLT, P_NLE, P_ORD} cmp_pred_t;

	typedef struct packed {
		op_t op;
		cmp_pred_t pred;
		logic dbl;
		logic scalar;
		logic [127:0] src1;
		logic [127:0] src2;
	} req_t;

	typedef struct packed {
		logic valid;
		logic dest_we;
		logic [3:0] lane_dflt;
		logic [127:0] value;
		logic cflags_we;
		logic [2:0] cflags;
		logic proceed;
		logic [127:0] opnd1;
		logic [127:0] opnd2;
		logic simd_fp_fault;
		logic illegal_opcode_fault;
	} resp_t;

	typedef struct packed {
		logic [31:0] simd_fp_ctrl_status_reg;
		logic os_simd_fault_support;
		logic [31:0] rdata;
		resp_t resp;
	} state_t;

	typedef struct packed {
		logic sign;
		logic nan;
		logic snan;
		logic inf;
		logic zero;
		logic den;
		logic man_zero;
		logic [10:0] exp;
	} fp_class_t;

endpackage : simd_fp_exc_pkg

// ### verilog/simd_fp_precompute_exceptions.sv
// Pre-computation exception unit: invalid, denormal, divide-by-zero.
// Assumes the decoder presents one request per cycle on the core clock
// and software reaches the control/status word over a plain port.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
module simd_fp_precompute_exceptions
	import simd_fp_exc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	// Operation request and answer
	input wire logic req_valid_i,
	input wire req_t req_i,
	output resp_t resp_o
);

	// ************************************************
	// Helpers
	// ************************************************
	// Classify one lane; single lanes sit in the low word
	function automatic fp_class_t classify(input logic [63:0] v, input logic dbl);
		fp_class_t c;
		logic emax;
		logic ez;
		logic qb;
		c.sign = dbl ? v[63] : v[31];
		c.exp = dbl ? v[62:52] : {3'h0, v[30:23]};
		emax = dbl ? &v[62:52] : &v[30:23];
		ez = dbl ? ~|v[62:52] : ~|v[30:23];
		c.man_zero = dbl ? ~|v[51:0] : ~|v[22:0];
		qb = dbl ? v[51] : v[22];
		c.nan = emax & !c.man_zero;
		c.snan = c.nan & !qb;
		c.inf = emax & c.man_zero;
		c.zero = ez & c.man_zero;
		c.den = ez & !c.man_zero;
		return c;
	endfunction : classify

	// Setting the top mantissa bit turns a signaling NaN quiet, payload kept
	function automatic logic [63:0] quiet(input logic [63:0] v, input logic dbl);
		return v | (dbl ? DBL_QUIET : SGL_QUIET);
	endfunction : quiet

	// ************************************************
	// State
	// ************************************************
	state_t st;
	state_t next_st;
	logic inv_any;
	logic den_any;
	logic dz_any;
	logic raise;
	logic nan0;
	// Per-lane scratch through zb, rewritten for every lane of the loop; then daz, the lane results and csr_w
	fp_class_t ca;
	fp_class_t cb;
	logic [63:0] a;
	logic [63:0] b;
	logic [63:0] dv;
	logic inv;
	logic dz;
	logic den;
	logic dflt;
	logic act;
	logic eff_sub;
	logic za;
	logic zb;
	logic daz;
	logic [127:0] val;
	logic [127:0] o1;
	logic [127:0] o2;
	logic [3:0] lane_dflt;
	logic [31:0] csr_w;

	// ************************************************
	// Per-lane detection and default results
	// ************************************************
	// Lanes are examined in one unrolled loop; scalar forms use lane 0 only
	always_comb begin
		inv_any = 1'b0;
		den_any = 1'b0;
		dz_any = 1'b0;
		nan0 = 1'b0;
		val = '0;
		lane_dflt = '0;
		o1 = req_i.src1;
		o2 = req_i.src2;
		ca = '0;
		cb = '0;
		a = '0;
		b = '0;
		dv = '0;
		inv = 1'b0;
		dz = 1'b0;
		den = 1'b0;
		dflt = 1'b0;
		act = 1'b0;
		eff_sub = 1'b0;
		za = 1'b0;
		zb = 1'b0;
		// Only denormals-are-zero steers detection; flush-to-zero is stored and never read
		daz = st.simd_fp_ctrl_status_reg[DAZ_BIT];
		for (int i = 0; i < 4; i++) begin
			// Ordered compares look at lane 0 only, whatever the scalar bit says
			act = (i == 0) || (!req_i.scalar && req_i.op != OP_COMI && (!req_i.dbl || i < 2));
			a = req_i.dbl ? req_i.src1[64*(i%2)+:64] : {32'h0, req_i.src1[32*i+:32]};
			b = req_i.dbl ? req_i.src2[64*(i%2)+:64] : {32'h0, req_i.src2[32*i+:32]};
			ca = classify(a, req_i.dbl);
			cb = classify(b, req_i.dbl);
			// Denormals read as signed zeros when enabled
			za = ca.zero | (daz & ca.den);
			zb = cb.zero | (daz & cb.den);
			inv = 1'b0;
			dz = 1'b0;
			dflt = 1'b0;
			dv = '0;
			eff_sub = (req_i.op == OP_SUB) || (req_i.op == OP_ADDSUB && (i % 2) == 0);
			case (req_i.op)
				OP_ADD, OP_SUB, OP_ADDSUB, OP_MUL, OP_DIV: begin
					if (ca.snan || cb.snan) begin
						inv = 1'b1;
						dv = quiet(ca.snan ? a : b, req_i.dbl);
					end else if (ca.nan || cb.nan) begin
						inv = 1'b0;
					end else if (req_i.op == OP_MUL) begin
						inv = (ca.inf && zb) || (za && cb.inf);
					end else if (req_i.op == OP_DIV) begin
						inv = (za && zb) || (ca.inf && cb.inf);
						dz = zb && !za && !ca.inf;
					end else begin
						inv = ca.inf && cb.inf && ((ca.sign ^ cb.sign) ^ eff_sub);
					end
					if (inv && !(ca.snan || cb.snan)) begin
						dv = req_i.dbl ? DBL_INDEF : {32'h0, SGL_INDEF};
					end
					if (dz) begin
						dv = req_i.dbl ? (DBL_INF | {ca.sign ^ cb.sign, 63'h0}) :
							{32'h0, SGL_INF | {ca.sign ^ cb.sign, 31'h0}};
					end
					dflt = inv | dz;
				end
				OP_SQRT: begin
					if (ca.snan) begin
						inv = 1'b1;
						dv = quiet(a, req_i.dbl);
					end else if (ca.sign && !za && !ca.nan) begin
						inv = 1'b1;
						dv = req_i.dbl ? DBL_INDEF : {32'h0, SGL_INDEF};
					end
					dflt = inv;
				end
				OP_MAX, OP_MIN: begin
					inv = ca.nan || cb.nan;
					dv = b;
					dflt = inv;
				end
				OP_CMP: begin
					// Quiet NaNs fault only for the relational predicates
					inv = ca.snan || cb.snan || ((ca.nan || cb.nan) && (req_i.pred == P_LT ||
						req_i.pred == P_LE || req_i.pred == P_NLT || req_i.pred == P_NLE));
					dflt = ca.nan || cb.nan;
					dv = (req_i.pred == P_NEQ || req_i.pred == P_UNORD || req_i.pred == P_NLT ||
						req_i.pred == P_NLE) ? '1 : '0;
				end
				OP_COMI: begin
					inv = ca.nan || cb.nan;
				end
				OP_CVT_FP: begin
					inv = ca.snan;
					dv = quiet(a, req_i.dbl);
					dflt = inv;
				end
				OP_CVT_INT: begin
					// Exactly the most negative integer still fits
					inv = ca.nan || ca.inf || (ca.exp >= (req_i.dbl ? DBL_INT_EXP : SGL_INT_EXP) &&
						!(ca.sign && ca.man_zero && ca.exp == (req_i.dbl ? DBL_INT_EXP : SGL_INT_EXP)));
					dv = {32'h0, INT_INDEF};
					dflt = inv;
				end
				default: begin
					inv = 1'b0;
				end
			endcase
			// Denormal check; integer conversions and approximations are exempt
			case (req_i.op)
				OP_CVT_INT, OP_CVT_FROM_INT, OP_APPROX: den = 1'b0;
				OP_SQRT, OP_CVT_FP: den = ca.den && !daz;
				default: den = (ca.den || cb.den) && !daz;
			endcase
			if (i == 0) begin
				nan0 = ca.nan || cb.nan;
			end
			if (act) begin
				// Packed flags are the OR of every active lane
				inv_any = inv_any | inv;
				den_any = den_any | den;
				dz_any = dz_any | dz;
				lane_dflt[i] = dflt;
				if (req_i.dbl) begin
					val[64*(i%2)+:64] = dflt ? dv : 64'h0;
					if (daz && ca.den) o1[64*(i%2)+:64] = {a[63], 63'h0};
					if (daz && cb.den) o2[64*(i%2)+:64] = {b[63], 63'h0};
				end else begin
					val[32*i+:32] = dflt ? dv[31:0] : 32'h0;
					if (daz && ca.den) o1[32*i+:32] = {a[31], 31'h0};
					if (daz && cb.den) o2[32*i+:32] = {b[31], 31'h0};
				end
			end
		end
		// Any unmasked condition stops the instruction
		raise = (inv_any && !st.simd_fp_ctrl_status_reg[INV_MASK_BIT]) ||
			(den_any && !st.simd_fp_ctrl_status_reg[DEN_MASK_BIT]) ||
			(dz_any && !st.simd_fp_ctrl_status_reg[DZ_MASK_BIT]);
	end

	// ************************************************
	// Next state: registers, flags and the answer
	// ************************************************
	// Detection sets flags after the software write, so a set is never lost
	always_comb begin
		csr_w = st.simd_fp_ctrl_status_reg;
		next_st = st;
		next_st.rdata = '0;
		next_st.resp.valid = 1'b0;
		next_st.resp.dest_we = 1'b0;
		next_st.resp.cflags_we = 1'b0;
		next_st.resp.proceed = 1'b0;
		next_st.resp.simd_fp_fault = 1'b0;
		next_st.resp.illegal_opcode_fault = 1'b0;
		// Reads return zero for unmapped addresses and reserved bits
		if (reg_re_i) begin
			case (reg_addr_i)
				CSR_ADDR: next_st.rdata = st.simd_fp_ctrl_status_reg;
				OS_CTRL_ADDR: next_st.rdata = 32'(st.os_simd_fault_support) << OS_SUPPORT_BIT;
				default: next_st.rdata = '0;
			endcase
		end
		if (reg_we_i && reg_addr_i == CSR_ADDR) begin
			csr_w = reg_wdata_i & CSR_WMASK;
		end
		// Only the OS support bit of that word is kept
		if (reg_we_i && reg_addr_i == OS_CTRL_ADDR) begin
			next_st.os_simd_fault_support = reg_wdata_i[OS_SUPPORT_BIT];
		end
		if (req_valid_i) begin
			csr_w[INV_FLAG_BIT] = csr_w[INV_FLAG_BIT] | inv_any;
			csr_w[DEN_FLAG_BIT] = csr_w[DEN_FLAG_BIT] | den_any;
			csr_w[DZ_FLAG_BIT] = csr_w[DZ_FLAG_BIT] | dz_any;
			// The answer comes with the instruction, one cycle after it
			next_st.resp.valid = 1'b1;
			next_st.resp.lane_dflt = raise ? 4'h0 : lane_dflt;
			next_st.resp.value = raise ? 128'h0 : val;
			next_st.resp.opnd1 = o1;
			next_st.resp.opnd2 = o2;
			next_st.resp.proceed = !raise;
			next_st.resp.dest_we = !raise && (|lane_dflt);
			next_st.resp.cflags_we = !raise && req_i.op == OP_COMI && nan0;
			next_st.resp.cflags = UNORD_FLAGS;
			next_st.resp.simd_fp_fault = raise && st.os_simd_fault_support;
			next_st.resp.illegal_opcode_fault = raise && !st.os_simd_fault_support;
		end
		next_st.simd_fp_ctrl_status_reg = csr_w;
	end

	// Masks come up set so defaults are produced from reset
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.simd_fp_ctrl_status_reg <= CSR_RESET;
			st.os_simd_fault_support <= OS_SUPPORT_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata_o = st.rdata;
	assign resp_o = st.resp;

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb_core @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	// Request shapes shared by two properties each, except s_req_clean, which serves one
	sequence s_req_masked_inv;
		req_valid_i && inv_any && !raise;
	endsequence

	sequence s_req_raise;
		req_valid_i && raise;
	endsequence

	sequence s_req_clean;
		req_valid_i && !raise;
	endsequence

	// Detection sets the matching flag at the next edge
	a_inv_flag_sets: assert property (req_valid_i && inv_any |=>
		st.simd_fp_ctrl_status_reg[INV_FLAG_BIT]) else $error("invalid flag not set");
	a_den_flag_sets: assert property (req_valid_i && den_any |=>
		st.simd_fp_ctrl_status_reg[DEN_FLAG_BIT]) else $error("denormal flag not set");
	a_dz_flag_sets: assert property (req_valid_i && dz_any |=>
		st.simd_fp_ctrl_status_reg[DZ_FLAG_BIT]) else $error("divide flag not set");
	// The invalid flag survives until software rewrites the word
	a_flag_stays_sticky: assert property (st.simd_fp_ctrl_status_reg[INV_FLAG_BIT] &&
		!(reg_we_i && reg_addr_i == CSR_ADDR) |=> st.simd_fp_ctrl_status_reg[INV_FLAG_BIT])
		else $error("invalid flag dropped");

	// A stopped instruction writes nothing and names its fault
	a_fault_no_write: assert property (s_req_raise |=> !resp_o.dest_we && !resp_o.cflags_we &&
		!resp_o.proceed && resp_o.value == 128'h0) else $error("faulting op wrote a result");
	a_fault_kind_os: assert property (s_req_raise |=>
		(resp_o.simd_fp_fault == $past(st.os_simd_fault_support)) &&
		(resp_o.illegal_opcode_fault != resp_o.simd_fp_fault)) else $error("wrong fault kind");

	// With nothing unmasked, masked invalid and divide-by-zero leave a result and all go on
	a_masked_inv_writes: assert property (s_req_masked_inv ##1 resp_o.valid |->
		resp_o.dest_we || resp_o.cflags_we) else $error("masked invalid gave no result");
	a_comi_unordered: assert property ((s_req_masked_inv and (req_i.op == OP_COMI)) |=>
		resp_o.cflags_we && resp_o.cflags == UNORD_FLAGS) else $error("unordered flags missing");
	a_masked_proceeds: assert property (s_req_clean |=>
		resp_o.proceed && !resp_o.simd_fp_fault && !resp_o.illegal_opcode_fault)
		else $error("masked op did not proceed");
	a_dz_default_written: assert property (req_valid_i && dz_any && !raise |=> resp_o.dest_we)
		else $error("masked divide gave no result");

	// Decode-side limits on which conditions may appear
	a_cvt_no_denorm: assert property (req_valid_i && (req_i.op == OP_CVT_INT ||
		req_i.op == OP_APPROX || req_i.op == OP_CVT_FROM_INT) |-> !den_any)
		else $error("conversion signalled denormal");
	a_daz_no_denorm: assert property (req_valid_i && st.simd_fp_ctrl_status_reg[DAZ_BIT] |->
		!den_any) else $error("zeroed denormal still signalled");
	a_dz_only_divide: assert property (req_valid_i && req_i.op != OP_DIV |-> !dz_any)
		else $error("divide flag outside a division");

	// The answer follows its request by exactly one cycle
	a_answer_in_one: assert property (req_valid_i |=> resp_o.valid ##1
		(resp_o.valid == $past(req_valid_i))) else $error("answer not one cycle after request");

endmodule : simd_fp_precompute_exceptions

// ### bench/tb_simd_fp_precompute_exceptions.sv
// Self-checking bench for the pre-computation exception unit.
// Drives register and request ports directly; no partner model.
`timescale 1ns/1ps
module tb_simd_fp_precompute_exceptions
	import simd_fp_exc_pkg::*;
;
	// ****************************************
	// Signals, operands and counters
	// ****************************************
	localparam logic [31:0] ONE = 32'h3F80_0000;
	localparam logic [31:0] NEG = 32'hBF80_0000;
	localparam logic [31:0] QNAN = 32'h7FC0_0001;
	localparam logic [31:0] SNAN = 32'h7F80_0001;
	localparam logic [31:0] NINF = 32'hFF80_0000;
	localparam logic [63:0] D_ONE = 64'h3FF0_0000_0000_0000;
	localparam logic [95:0] ONES3 = {ONE, ONE, ONE};
	logic ref_clk_i;
	logic rst_n_i;
	logic [3:0] reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic reg_we_i;
	logic reg_re_i;
	logic [31:0] reg_rdata_o;
	logic req_valid_i;
	req_t req_i;
	resp_t resp_o;
	int fails;
	int checks_done;
	logic [31:0] exp_w;
	op_t t_op[5] = '{OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_DIV};
	logic [31:0] t_a[5] = '{SGL_INF, SGL_INF, SGL_INF, 32'h0, SGL_INF};
	logic [31:0] t_b[5] = '{NINF, SGL_INF, 32'h0, 32'h0, SGL_INF};
	logic [31:0] c_src[3] = '{SGL_INF, 32'h4F00_0000, 32'hCF00_0000};

	simd_fp_precompute_exceptions DUT (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i),
		.reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o),
		.req_valid_i(req_valid_i),
		.req_i(req_i),
		.resp_o(resp_o)
	);

	// 125 MHz core clock
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	// ****************************************
	// Compare, access and closing tasks
	// ****************************************
	task automatic cmp_bit(input string what, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_bit

	task automatic cmp_vec(input string what, input logic [127:0] e, input logic [127:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_vec

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_we_i <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_re_i <= 1'b0;
		#1;
		cmp_vec("read word", {96'h0, e}, {96'h0, reg_rdata_o});
	endtask : rd

	task automatic csr(input logic [31:0] e);
		rd(CSR_ADDR, e);
	endtask : csr

	task automatic clr();
		wr(CSR_ADDR, CSR_RESET);
	endtask : clr

	// One request; the answer is sampled in the cycle it stands
	task automatic issue(input op_t o, input cmp_pred_t p, input logic d, input logic s,
		input logic [127:0] a, input logic [127:0] b);
		@(posedge ref_clk_i);
		req_valid_i <= 1'b1;
		req_i <= '{op: o, pred: p, dbl: d, scalar: s, src1: a, src2: b};
		@(posedge ref_clk_i);
		req_valid_i <= 1'b0;
		#1;
		cmp_bit("answer valid", 1'b1, resp_o.valid);
	endtask : issue

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask : done

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		fails++;
		conclude();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		fails = 0;
		checks_done = 0;
		rst_n_i = 1'b0;
		reg_addr_i = 4'h0;
		reg_wdata_i = 32'h0;
		reg_we_i = 1'b0;
		reg_re_i = 1'b0;
		req_valid_i = 1'b0;
		req_i = '0;
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		csr(CSR_RESET);
		rd(OS_CTRL_ADDR, 32'h0);
		done("reset");
		// Masked max with a quiet NaN, then flag stickiness
		issue(OP_MAX, P_EQ, 1'b0, 1'b0, {ONES3, QNAN}, {ONES3, NEG});
		cmp_bit("dest write", 1'b1, resp_o.dest_we);
		cmp_vec("max value", {96'h0, NEG}, resp_o.value);
		cmp_vec("default lanes", 128'h1, {124'h0, resp_o.lane_dflt});
		cmp_bit("proceed", 1'b1, resp_o.proceed);
		issue(OP_ADD, P_EQ, 1'b0, 1'b0, {ONES3, ONE}, {ONES3, ONE});
		csr(32'h0000_0381);
		clr();
		csr(CSR_RESET);
		done("max and sticky");
		// Packed lanes: quieting, negative root, lane OR
		issue(OP_SQRT, P_EQ, 1'b0, 1'b0, {ONE, ONE, NEG, SNAN}, {ONES3, ONE});
		cmp_vec("root value", {64'h0, SGL_INDEF, QNAN}, resp_o.value);
		csr(32'h0000_0381);
		clr();
		issue(OP_ADD, P_EQ, 1'b0, 1'b0, {ONE, SNAN, ONE, ONE}, {ONES3, ONE});
		cmp_vec("add value", {32'h0, QNAN, 64'h0}, resp_o.value);
		cmp_vec("default lanes", 128'h4, {124'h0, resp_o.lane_dflt});
		clr();
		issue(OP_ADD, P_EQ, 1'b0, 1'b0, {ONE, QNAN, ONE, ONE}, {ONES3, ONE});
		csr(CSR_RESET);
		done("packed lanes");
		// Invalid arithmetic on infinities and zeros
		for (int i = 0; i < 5; i++) begin
			clr();
			issue(t_op[i], P_EQ, 1'b0, 1'b1, {ONES3, t_a[i]}, {ONES3, t_b[i]});
			cmp_vec("indefinite", {96'h0, SGL_INDEF}, resp_o.value);
			csr(32'h0000_0381);
		end
		done("invalid arithmetic");
		// Every compare predicate against a quiet NaN
		for (int p = 0; p < 8; p++) begin
			clr();
			issue(OP_CMP, cmp_pred_t'(p), 1'b0, 1'b1, {ONES3, QNAN}, {ONES3, ONE});
			exp_w = (p inside {3, 4, 5, 6}) ? 32'hFFFF_FFFF : 32'h0;
			cmp_vec("compare mask", {96'h0, exp_w}, resp_o.value);
			csr(CSR_RESET | ((p inside {1, 2, 5, 6}) ? 32'h1 : 32'h0));
		end
		clr();
		issue(OP_COMI, P_EQ, 1'b0, 1'b1, {ONES3, QNAN}, {ONES3, ONE});
		cmp_bit("flags write", 1'b1, resp_o.cflags_we);
		cmp_vec("flags", {125'h0, UNORD_FLAGS}, {125'h0, resp_o.cflags});
		csr(32'h0000_0381);
		done("compares");
		// Conversions: integer range edges and precision change
		for (int i = 0; i < 3; i++) begin
			clr();
			issue(OP_CVT_INT, P_EQ, 1'b0, 1'b1, {ONES3, c_src[i]}, {ONES3, ONE});
			if (i < 2) begin
				cmp_vec("int indefinite", {96'h0, INT_INDEF}, resp_o.value);
			end
			csr(i < 2 ? 32'h0000_0381 : CSR_RESET);
		end
		clr();
		issue(OP_CVT_FP, P_EQ, 1'b0, 1'b1, {ONES3, SNAN}, {ONES3, ONE});
		cmp_bit("dest write", 1'b1, resp_o.dest_we);
		cmp_vec("convert value", {96'h0, QNAN}, resp_o.value);
		csr(32'h0000_0381);
		done("conversions");
		// Denormal operands, exempt operations, zeroing
		clr();
		issue(OP_ADD, P_EQ, 1'b0, 1'b1, {ONES3, 32'h0000_0001}, {ONES3, ONE});
		csr(32'h0000_0382);
		for (int i = 0; i < 2; i++) begin
			clr();
			issue(i ? OP_APPROX : OP_CVT_INT, P_EQ, 1'b0, 1'b1, {ONES3, 32'h1}, {ONES3, ONE});
			csr(CSR_RESET);
		end
		wr(CSR_ADDR, 32'h0000_03C0);
		issue(OP_ADD, P_EQ, 1'b0, 1'b1, {ONES3, 32'h8000_0001}, {ONES3, ONE});
		cmp_vec("zeroed operand", {ONES3, 32'h8000_0000}, resp_o.opnd1);
		cmp_vec("second operand", {ONES3, ONE}, resp_o.opnd2);
		csr(32'h0000_03C0);
		done("denormals");
		// Divide by zero and zero over zero with flush-to-zero set
		wr(CSR_ADDR, 32'h0000_8380);
		issue(OP_DIV, P_EQ, 1'b1, 1'b1, {D_ONE, D_ONE}, {D_ONE, 64'h0});
		cmp_vec("signed infinity", {64'h0, DBL_INF}, resp_o.value);
		csr(32'h0000_8384);
		issue(OP_DIV, P_EQ, 1'b1, 1'b1, {D_ONE, 64'h0}, {D_ONE, 64'h0});
		cmp_vec("indefinite", {64'h0, DBL_INDEF}, resp_o.value);
		csr(32'h0000_8385);
		done("divide");
		// Unmasked invalid: fault kind follows the support bit
		for (int i = 0; i < 2; i++) begin
			wr(CSR_ADDR, 32'h0000_0300);
			wr(OS_CTRL_ADDR, i ? 32'h0 : 32'h0000_0400);
			rd(OS_CTRL_ADDR, i ? 32'h0 : 32'h0000_0400);
			issue(OP_MAX, P_EQ, 1'b0, 1'b0, {ONES3, QNAN}, {ONES3, NEG});
			cmp_bit("fault", !i, resp_o.simd_fp_fault);
			cmp_bit("opcode fault", i == 1, resp_o.illegal_opcode_fault);
			cmp_bit("proceed", 1'b0, resp_o.proceed);
			cmp_bit("dest write", 1'b0, resp_o.dest_we);
			cmp_vec("operand kept", {ONES3, QNAN}, resp_o.opnd1);
			csr(32'h0000_0301);
		end
		done("unmasked");
		// Reserved bits and an unmapped address
		wr(CSR_ADDR, 32'hFFFF_FFFF);
		csr(CSR_WMASK);
		wr(4'h8, 32'hFFFF_FFFF);
		rd(4'h8, 32'h0);
		done("register map");
		conclude();
	end

endmodule : tb_simd_fp_precompute_exceptions
